// ### core/idw_pkg.sv
package idw_pkg;
    // word indexes of the page slice this block builds
    localparam logic [7:0] IDW_W_CAP_LO = 8'h39;
    localparam logic [7:0] IDW_W_CAP_HI = 8'h3A;
    localparam logic [7:0] IDW_W_MULT = 8'h3B;
    localparam logic [7:0] IDW_W_LBA_LO = 8'h3C;
    localparam logic [7:0] IDW_W_LBA_HI = 8'h3D;
    localparam logic [7:0] IDW_W_SDMA = 8'h3E;
    localparam logic [7:0] IDW_W_MDMA = 8'h3F;
    localparam logic [7:0] IDW_W_PIO = 8'h40;
    localparam logic [7:0] IDW_W_CYC_FIRST = 8'h41;
    localparam logic [7:0] IDW_W_CYC_LAST = 8'h44;
    localparam logic [7:0] IDW_W_RSV_FIRST = 8'h45;
    localparam logic [7:0] IDW_W_RSV_LAST = 8'h4F;
    localparam logic [7:0] IDW_W_MAJOR = 8'h50;
    localparam logic [7:0] IDW_W_MINOR = 8'h51;
    localparam logic [7:0] IDW_W_CMDSET = 8'h52;
    localparam logic [7:0] IDW_W_FIRST = 8'h39;
    localparam logic [7:0] IDW_W_LAST = 8'h52;
    // fixed field values
    localparam logic [7:0] IDW_MULT_VALID_HI = 8'h01;
    localparam logic [7:0] IDW_SDMA_MASK = 8'h07;
    localparam logic [7:0] IDW_MDMA_MASK = 8'h07;
    localparam logic [15:0] IDW_PIO_ADV = 16'h0003;
    localparam logic [15:0] IDW_CYCLE_NS = 16'h0078;
    localparam logic [15:0] IDW_RESERVED = 16'h0000;
    localparam logic [15:0] IDW_MAJOR_VER = 16'h003E;
    localparam logic [15:0] IDW_MINOR_VER = 16'h0000;
    localparam logic [15:0] IDW_CMDSET_SUP = 16'h7C6B;
    // live drive configuration
    typedef struct packed {
        logic [15:0] cyls;
        logic [15:0] heads;
        logic [15:0] spt;
        logic [7:0] mult_cnt;
        logic [31:0] lba_total;
        logic [7:0] sdma_active;
        logic [7:0] mdma_active;
    } idw_cfg_t;
    // one page word toward the sector buffer
    typedef struct packed {
        logic [7:0] idx;
        logic [15:0] data;
    } idw_word_t;
    // sequencer states, gray along the path
    typedef enum logic [1:0] {
        IDW_IDLE = 2'b00,
        IDW_CALC = 2'b01,
        IDW_EMIT = 2'b11,
        IDW_DONE = 2'b10
    } idw_state_t;
endpackage : idw_pkg

// ### core/idw_cap_mul.sv
`timescale 1ns/1ps
// two-stage capacity multiply: cylinders * heads * sectors
module idw_cap_mul (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // operands
    input wire logic [15:0] i_cyls,
    input wire logic [15:0] i_heads,
    input wire logic [15:0] i_spt,
    // product, valid two edges after operands
    output logic [31:0] o_cap
);
    logic [31:0] ch_r; // cylinders times heads
    logic [15:0] spt_r; // sectors held in step

    // stage one; split so timing closes at 125 MHz
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ch_r <= 32'h0000_0000;
            spt_r <= 16'h0000;
        end else begin
            ch_r <= {16'h0000, i_cyls} * {16'h0000, i_heads};
            spt_r <= i_spt;
        end
    end

    // stage two; low 32 bits kept, fits the two-word field
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_cap <= 32'h0000_0000;
        end else begin
            o_cap <= 32'(ch_r * {16'h0000, spt_r});
        end
    end
endmodule : idw_cap_mul

// ### core/idw_word_mux.sv
`timescale 1ns/1ps
// word selector for indexes 57 to 82
module idw_word_mux (
    // selection
    input wire logic [7:0] i_idx,
    // snapshot values
    input wire idw_pkg::idw_cfg_t i_cfg,
    input wire logic [31:0] i_cap,
    // selected word
    output logic [15:0] o_data
);
    import idw_pkg::*;

    // pure decode; snapshot kept by the caller
    always_comb begin
        o_data = IDW_RESERVED;
        if (i_idx == IDW_W_CAP_LO) begin
            o_data = i_cap[15:0];
        end else if (i_idx == IDW_W_CAP_HI) begin
            o_data = i_cap[31:16];
        end else if (i_idx == IDW_W_MULT) begin
            o_data = {IDW_MULT_VALID_HI, i_cfg.mult_cnt};
        end else if (i_idx == IDW_W_LBA_LO) begin
            o_data = i_cfg.lba_total[15:0];
        end else if (i_idx == IDW_W_LBA_HI) begin
            o_data = i_cfg.lba_total[31:16];
        end else if (i_idx == IDW_W_SDMA) begin
            o_data = {i_cfg.sdma_active, IDW_SDMA_MASK};
        end else if (i_idx == IDW_W_MDMA) begin
            o_data = {i_cfg.mdma_active, IDW_MDMA_MASK};
        end else if (i_idx == IDW_W_PIO) begin
            o_data = IDW_PIO_ADV;
        end else if (i_idx >= IDW_W_CYC_FIRST && i_idx <= IDW_W_CYC_LAST) begin
            o_data = IDW_CYCLE_NS;
        end else if (i_idx >= IDW_W_RSV_FIRST && i_idx <= IDW_W_RSV_LAST) begin
            o_data = IDW_RESERVED;
        end else if (i_idx == IDW_W_MAJOR) begin
            o_data = IDW_MAJOR_VER;
        end else if (i_idx == IDW_W_MINOR) begin
            o_data = IDW_MINOR_VER;
        end else if (i_idx == IDW_W_CMDSET) begin
            o_data = IDW_CMDSET_SUP;
        end
    end
endmodule : idw_word_mux

// ### core/idw_page_builder.sv
`timescale 1ns/1ps
// Contract
// - identify: busy, fill buffer, then data request
// - words 57-58 hold cylinders*heads*sectors
// - word 59 upper byte reads 01
// - word 59 low byte: current multiple count
// - words 60-61: LBA user sector total
// - word 62: single DMA active, mask 07
// - word 62 keeps the older layout
// - word 63: multiword DMA active, mask 07
// - word 64 reads 0003
// - words 65-68 each read 0078
// - words 69-79 read zero
// - word 80 reads 003E
// - word 81 reads 0000
// - word 82 reads 7C6B, upper flags
// - word 82 middle flags per 7C6B
// - word 82 low flags per 7C6B
module idw_page_builder (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // command side
    input wire logic i_start,
    input wire idw_pkg::idw_cfg_t i_cfg,
    // sector buffer write port
    input wire logic i_buf_ready,
    output logic o_buf_we,
    output idw_pkg::idw_word_t o_buf_word,
    // task-file status side
    output logic o_busy,
    output logic o_drq_set,
    output logic o_irq
);
    import idw_pkg::*;

    idw_state_t state_r; // sequencer state
    idw_state_t state_nxt; // next state
    idw_cfg_t snap_r; // config frozen for this build
    logic [7:0] idx_r; // word being written
    logic [1:0] wait_r; // multiplier latency count
    logic [31:0] cap; // capacity product
    logic [15:0] word_data; // selected word
    logic emit_ok; // a word goes out this cycle

    assign emit_ok = (state_r == IDW_EMIT) && i_buf_ready;

    // capacity from the frozen snapshot
    idw_cap_mul u_mul (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_cyls(snap_r.cyls),
        .i_heads(snap_r.heads),
        .i_spt(snap_r.spt),
        .o_cap(cap)
    );

    // word selection
    idw_word_mux u_mux (
        .i_idx(idx_r),
        .i_cfg(snap_r),
        .i_cap(cap),
        .o_data(word_data)
    );

    // next state
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            IDW_IDLE: begin
                if (i_start) begin
                    state_nxt = IDW_CALC;
                end
            end
            IDW_CALC: begin
                if (wait_r == 2'h2) begin
                    state_nxt = IDW_EMIT;
                end
            end
            IDW_EMIT: begin
                if (emit_ok && idx_r == IDW_W_LAST) begin
                    state_nxt = IDW_DONE;
                end
            end
            default: begin
                state_nxt = IDW_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state_r <= IDW_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // snapshot; taken per build so stale settings never leak
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            snap_r <= '0;
        end else if (state_r == IDW_IDLE && i_start) begin
            snap_r <= i_cfg;
        end
    end

    // multiplier latency wait
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            wait_r <= 2'h0;
        end else if (state_r == IDW_CALC) begin
            wait_r <= wait_r + 2'h1;
        end else begin
            wait_r <= 2'h0;
        end
    end

    // word index walk; back-pressure holds it
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            idx_r <= IDW_W_FIRST;
        end else if (state_r == IDW_IDLE) begin
            idx_r <= IDW_W_FIRST;
        end else if (emit_ok && idx_r != IDW_W_LAST) begin
            idx_r <= idx_r + 8'h01;
        end
    end

    // buffer write outputs registered
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_buf_we <= 1'b0;
            o_buf_word <= '0;
        end else begin
            o_buf_we <= emit_ok;
            if (emit_ok) begin
                o_buf_word <= '{idx: idx_r, data: word_data};
            end
        end
    end

    // busy while building; data request and irq once filled
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_busy <= 1'b0;
            o_drq_set <= 1'b0;
            o_irq <= 1'b0;
        end else begin
            o_busy <= (state_nxt != IDW_IDLE);
            o_drq_set <= (state_r == IDW_DONE);
            o_irq <= (state_r == IDW_DONE);
        end
    end

    // start taken from idle
    sequence start_taken_s;
        state_r == IDW_IDLE && i_start;
    endsequence

    // three calc cycles, then the first emit; the product settles meanwhile
    sequence calc_run_s;
        (state_r == IDW_CALC) [*3] ##1 (state_r == IDW_EMIT);
    endsequence

    // last word of the slice leaving
    sequence last_write_s;
        o_buf_we && o_buf_word.idx == IDW_W_LAST;
    endsequence

    // independent capacity reference, cut to the two-word field
    logic [31:0] cap_ref; // low 32 bits of cylinders * heads * sectors
    assign cap_ref = {16'h0000, snap_r.cyls} * {16'h0000, snap_r.heads}
        * {16'h0000, snap_r.spt};

    // busy rises the edge after start
    busy_on_start_a: assert property (@(posedge i_clk) disable iff (i_rst)
        start_taken_s |=> o_busy)
        else $error("busy not raised on start");

    // multiplier gets its full latency before word 57
    calc_wait_a: assert property (@(posedge i_clk) disable iff (i_rst)
        start_taken_s |=> calc_run_s)
        else $error("calc phase length wrong");

    // settings frozen at the start edge
    snap_fresh_a: assert property (@(posedge i_clk) disable iff (i_rst)
        start_taken_s |=> snap_r == $past(i_cfg))
        else $error("snapshot not taken on start");

    // every word goes out under busy
    busy_during_fill_a: assert property (@(posedge i_clk) disable iff (i_rst)
        o_buf_we |-> o_busy)
        else $error("word written while not busy");

    // only indexes of this slice are written
    idx_range_a: assert property (@(posedge i_clk) disable iff (i_rst)
        o_buf_we |-> (o_buf_word.idx >= IDW_W_FIRST && o_buf_word.idx <= IDW_W_LAST))
        else $error("word index out of slice");

    // data request only after last word written
    drq_after_fill_a: assert property (@(posedge i_clk) disable iff (i_rst)
        last_write_s |-> ##1 (o_drq_set && o_irq))
        else $error("data request not after fill");

    // no data request while still busy with words
    drq_not_busy_a: assert property (@(posedge i_clk) disable iff (i_rst)
        o_drq_set |-> !o_busy)
        else $error("data request during build");

    // data request is a single pulse
    drq_one_cycle_a: assert property (@(posedge i_clk) disable iff (i_rst)
        o_drq_set |=> !o_drq_set)
        else $error("data request longer than one cycle");

    // interrupt and data request move together
    irq_with_drq_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (o_drq_set || o_irq) |-> (o_drq_set && o_irq))
        else $error("interrupt apart from data request");

    // capacity low half first
    cap_word_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (o_buf_we && o_buf_word.idx == IDW_W_CAP_LO) |->
        o_buf_word.data == cap_ref[15:0])
        else $error("capacity low word wrong");

    // capacity high half; bits past 32 are lost by design
    cap_high_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (o_buf_we && o_buf_word.idx == IDW_W_CAP_HI) |->
        o_buf_word.data == cap_ref[31:16])
        else $error("capacity high word wrong");

    // word 59 layout
    mult_word_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (o_buf_we && o_buf_word.idx == IDW_W_MULT) |->
        o_buf_word.data == {8'h01, snap_r.mult_cnt})
        else $error("multiple word wrong");

    // lba low half first
    lba_low_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (o_buf_we && o_buf_word.idx == IDW_W_LBA_LO) |->
        o_buf_word.data == snap_r.lba_total[15:0])
        else $error("lba low word wrong");

    // lba high half
    lba_word_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (o_buf_we && o_buf_word.idx == IDW_W_LBA_HI) |->
        o_buf_word.data == snap_r.lba_total[31:16])
        else $error("lba word wrong");

    // dma support masks
    dma_word_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (o_buf_we && (o_buf_word.idx == IDW_W_SDMA || o_buf_word.idx == IDW_W_MDMA)) |->
        o_buf_word.data[7:0] == 8'h07)
        else $error("dma mask wrong");

    // single-word dma active mode in the high byte, older layout
    sdma_active_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (o_buf_we && o_buf_word.idx == IDW_W_SDMA) |->
        o_buf_word.data[15:8] == snap_r.sdma_active)
        else $error("single dma active byte wrong");

    // multiword dma active mode in the high byte
    mdma_active_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (o_buf_we && o_buf_word.idx == IDW_W_MDMA) |->
        o_buf_word.data[15:8] == snap_r.mdma_active)
        else $error("multiword dma active byte wrong");

    // advanced pio modes
    pio_word_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (o_buf_we && o_buf_word.idx == IDW_W_PIO) |->
        o_buf_word.data == 16'h0003)
        else $error("pio word wrong");

    // cycle times
    cycle_word_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (o_buf_we && o_buf_word.idx >= IDW_W_CYC_FIRST && o_buf_word.idx <= IDW_W_CYC_LAST) |->
        o_buf_word.data == 16'h0078)
        else $error("cycle time word wrong");

    // reserved stretch reads zero
    reserved_word_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (o_buf_we && o_buf_word.idx >= IDW_W_RSV_FIRST && o_buf_word.idx <= IDW_W_RSV_LAST) |->
        o_buf_word.data == 16'h0000)
        else $error("reserved word not zero");

    // major version bitmap
    major_word_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (o_buf_we && o_buf_word.idx == IDW_W_MAJOR) |->
        o_buf_word.data == 16'h003E)
        else $error("major version word wrong");

    // minor version not reported
    minor_word_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (o_buf_we && o_buf_word.idx == IDW_W_MINOR) |->
        o_buf_word.data == 16'h0000)
        else $error("minor version word wrong");

    // command set word in full
    fixed_word_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (o_buf_we && o_buf_word.idx == IDW_W_CMDSET) |->
        o_buf_word.data == 16'h7C6B)
        else $error("command set word wrong");

    // interrupt, cache, packet and feature-set flags of the command set word
    cmd_low_flags_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (o_buf_we && o_buf_word.idx == IDW_W_CMDSET) |->
        o_buf_word.data[8:0] == 9'h06B)
        else $error("command set low flags wrong");
endmodule : idw_page_builder

// ### verification/idw_buf_model.sv
`timescale 1ns/1ps
// sector buffer stand-in on the page write port
module idw_buf_model (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // bench control
    input wire logic i_clear,
    input wire logic i_slow,
    // write port from the builder
    input wire logic i_we,
    input wire idw_pkg::idw_word_t i_word,
    output logic o_ready,
    // host reading of the command-set word
    output logic o_no_notify
);
    import idw_pkg::*;
    logic [15:0] page [0:255]; // captured page words
    int n_words; // words taken this build
    logic order_bad; // set on any out-of-order index
    logic [7:0] next_idx; // index expected next
    logic [1:0] pace_r; // slow-mode pacing
    // slow mode takes one word in three, so the builder must stall without loss
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            pace_r <= 2'h0;
        end else begin
            pace_r <= (pace_r == 2'h2) ? 2'h0 : pace_r + 2'h1;
        end
    end
    assign o_ready = !i_slow || (pace_r == 2'h0);
    // capture words and watch their order
    always_ff @(posedge i_clk) begin
        if (i_clear) begin
            n_words <= 0;
            next_idx <= 8'h39;
            order_bad <= 1'b0;
        end else if (i_we) begin
            page[i_word.idx] <= i_word.data;
            n_words <= n_words + 1;
            next_idx <= i_word.idx + 8'h01;
            if (i_word.idx !== next_idx) begin
                order_bad <= 1'b1;
            end
        end
    end
    // all zeros or all ones means no notification
    assign o_no_notify = (page[8'h52] === 16'h0000) || (page[8'h52] === 16'hFFFF);
endmodule : idw_buf_model

// ### verification/identify_words_57_to_82_bench.sv
`timescale 1ns/1ps
module identify_words_57_to_82_bench;
    import idw_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic start = 1'b0;
    logic clr = 1'b0; // clears the model on run_build starts, not on pokes or the reset_mid start
    logic slow = 1'b0;
    idw_cfg_t cfg = '0;
    logic buf_ready, buf_we, busy, drq_set, irq, no_notify;
    idw_word_t buf_word;
    int n_errors = 0;
    int n_compared = 0;
    int n_drq = 0;
    // 125 MHz clock
    always #4 clk = ~clk;
    idw_page_builder i_idw_page_builder (.i_clk(clk), .i_rst(rst), .i_start(start),
        .i_cfg(cfg), .i_buf_ready(buf_ready), .o_buf_we(buf_we), .o_buf_word(buf_word),
        .o_busy(busy), .o_drq_set(drq_set), .o_irq(irq));
    idw_buf_model i_idw_buf_model (.i_clk(clk), .i_rst(rst), .i_clear(clr), .i_slow(slow),
        .i_we(buf_we), .i_word(buf_word), .o_ready(buf_ready), .o_no_notify(no_notify));
    // compare tasks, one per kind of result
    task automatic check16(input string what, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask : check16
    task automatic check_bit(input string what, input logic e, input logic g);
        check16(what, {15'h0000, e}, {15'h0000, g});
    endtask : check_bit
    task automatic give_verdict;
        if (n_errors == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : give_verdict
    // page word as the host should read it
    function automatic logic [15:0] exp_word(input int i, input idw_cfg_t c);
        logic [47:0] cap;
        cap = c.cyls * c.heads * c.spt; // truncated to 32 bits below
        case (i)
            57: return cap[15:0];
            58: return cap[31:16];
            59: return {8'h01, c.mult_cnt};
            60: return c.lba_total[15:0];
            61: return c.lba_total[31:16];
            62: return {c.sdma_active, 8'h07};
            63: return {c.mdma_active, 8'h07};
            64: return 16'h0003;
            65, 66, 67, 68: return 16'h0078;
            80: return 16'h003E;
            82: return 16'h7C6B;
            default: return 16'h0000; // reserved words and minor version
        endcase
    endfunction : exp_word
    // one page word against the rules
    task automatic check_word(input int i, input idw_cfg_t c);
        check16($sformatf("word %0d", i), exp_word(i, c), i_idw_buf_model.page[i]);
    endtask : check_word
    // drq and irq must pulse together
    always @(posedge clk) begin
        #1;
        if (drq_set === 1'b1) begin
            n_drq++;
        end
        if (drq_set === 1'b1 || irq === 1'b1) begin
            check_bit("irq with drq", 1'b1, irq);
            check_bit("drq with irq", 1'b1, drq_set);
        end
    end
    // one build; poke fires an ignored start mid-build, cfg is disturbed after the snapshot
    task automatic run_build(input idw_cfg_t c, input logic s, input logic poke);
        int k;
        int d0;
        d0 = n_drq;
        @(posedge clk);
        cfg <= c;
        slow <= s;
        start <= 1'b1;
        clr <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        clr <= 1'b0;
        cfg <= ~c;
        #1;
        check_bit("busy after start", 1'b1, busy);
        k = 0;
        while (drq_set !== 1'b1 && k < 400) begin
            @(posedge clk);
            if (poke) start <= (k == 8);
            #1;
            k++;
        end
        if (k == 400) begin
            n_errors++;
            give_verdict();
        end
        check_bit("busy at drq", 1'b0, busy);
        check16("word count", 16'h001A, i_idw_buf_model.n_words[15:0]);
        check_bit("order error", 1'b0, i_idw_buf_model.order_bad);
        for (int i = 57; i <= 61; i++) begin
            check_word(i, c);
        end
        for (int i = 62; i <= 63; i++) begin
            check_word(i, c);
        end
        for (int i = 64; i <= 82; i++) begin
            check_word(i, c);
        end
        check_bit("notify missing", 1'b0, no_notify);
        @(posedge clk);
        #1;
        check_bit("drq one cycle", 1'b0, drq_set);
        repeat (40) @(posedge clk);
        #1;
        check16("drq pulses", 16'h0001, 16'(n_drq - d0));
        check16("late words", 16'h001A, i_idw_buf_model.n_words[15:0]);
    endtask : run_build
    // reset lands in mid-build and must clear busy and the buffer write
    task automatic reset_mid(input idw_cfg_t c);
        @(posedge clk);
        cfg <= c;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        repeat (12) @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        #1;
        check_bit("busy in reset", 1'b0, busy);
        check_bit("write in reset", 1'b0, buf_we);
        @(posedge clk);
        rst <= 1'b0;
    endtask : reset_mid
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        #1;
        check_bit("busy after reset", 1'b0, busy);
        run_build('{16'h3FFF, 16'h0010, 16'h003F, 8'h10, 32'h0FB0_1234, 8'h02, 8'h04}, 1'b0, 1'b0);
        run_build('{16'hFFFF, 16'h00FF, 16'h00FF, 8'h01, 32'hFFFF_FFFF, 8'h01, 8'h02}, 1'b1, 1'b1);
        reset_mid('{16'h1234, 16'h0002, 16'h0003, 8'h08, 32'h0000_ABCD, 8'h04, 8'h01});
        run_build('0, 1'b0, 1'b0);
        give_verdict();
    end
endmodule : identify_words_57_to_82_bench
